/* File: src/brs_pkg.sv */
// Package: timing counts and mode codes of the brown-out reset sequencer
package brs_pkg;

	// Clock 40 MHz
	localparam int unsigned CLK_HZ             = 40000000;
	// Power-up timer, nominal
	localparam int unsigned PUT_MS             = 64;
	localparam int unsigned PUT_CYCLES         = (CLK_HZ / 1000) * PUT_MS;
	// Brown-out filter duration default, in microseconds
	localparam int unsigned FILT_US            = 1;
	localparam int unsigned FILT_CYCLES        =
		((CLK_HZ / 1000000) * FILT_US < 1) ? 1 :
		(CLK_HZ / 1000000) * FILT_US;

	localparam int unsigned CNT_W              = 22;

	// Mode field codes
	localparam logic [1:0]  MODE_ALWAYS_ON     = 2'h3;
	localparam logic [1:0]  MODE_OFF_IN_SLEEP  = 2'h2;
	localparam logic [1:0]  MODE_SOFTWARE      = 2'h1;
	localparam logic [1:0]  MODE_ALWAYS_OFF    = 2'h0;

	// Reset value of the software enable
	localparam logic        SW_EN_RESET        = 1'b1;

	// Sequencer states, Gray along the power-up path
	typedef enum logic [1:0] {
		BRS_ST_HOLD    = 2'b00,
		BRS_ST_TIMING  = 2'b01,
		BRS_ST_WAITRDY = 2'b11,
		BRS_ST_RUN     = 2'b10
	} brs_state_t;

endpackage : brs_pkg

/* File: src/brs_counter.sv */
// Counter with restart and terminal flag
`timescale 1ns/10ps

module brs_counter #(
	parameter int unsigned WIDTH = 22
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic             clear_i,
	input  wire logic             run_i,
	input  wire logic [WIDTH-1:0] limit_i,
	output logic                  done_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             done;
	} brs_cnt_state_t;

	brs_cnt_state_t state;
	brs_cnt_state_t next_state;

	always_comb begin
		next_state = state;
		if (clear_i) begin
			next_state.count = '0;
			next_state.done  = 1'b0;
		end else if (run_i && !state.done) begin
			if (state.count + WIDTH'(1) >= limit_i) begin
				next_state.done = 1'b1;
			end
			next_state.count = state.count + WIDTH'(1);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign done_o = state.done;

endmodule : brs_counter

/* File: src/brs_sequencer.sv */
// Brown-out reset sequencer: core reset and start gate
`timescale 1ns/10ps

// Overview of operation
// - Hold core reset while power-on detect low
// - Power-up timer gives nominal 64 ms
// - Core reset held while timer counts
// - Timer enable bit active low, set bypasses
// - Timer starts after power-on and brown-out release
// - Hold reset while active detector sees low
// - Mode 11: always active, start waits ready
// - Mode 11: active in sleep, no wake delay
// - Mode 10: off in sleep, waits ready
// - Mode 01: software bit enables, no start wait
// - Mode 01: protect once ready, ready visible
// - Mode 01: sleep does not change protection
// - Mode 01 enable 0: off, run immediately
// - Forced-on modes: ready before execution, start waits ready
// - One configuration bit selects threshold level
// - Low supply must persist beyond filter time
module brs_sequencer #(
	parameter int unsigned PUT_CYCLES  = brs_pkg::PUT_CYCLES,
	parameter int unsigned FILT_CYCLES = brs_pkg::FILT_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       power_on_ok_i,
	input  wire logic       supply_low_i,
	input  wire logic       detector_ready_i,
	input  wire logic       sleep_i,
	input  wire logic [1:0] brownout_mode_select_i,
	input  wire logic       brownout_level_select_i,
	input  wire logic       power_up_timer_disable_i,
	input  wire logic       sw_enable_we_i,
	input  wire logic       sw_enable_wdata_i,
	output logic            detector_enable_o,
	output logic            brownout_level_o,
	output logic            software_brownout_enable_o,
	output logic            brownout_ready_flag_o,
	output logic            brownout_reset_o,
	output logic            power_up_timer_running_o,
	output logic            core_reset_o,
	output logic            core_start_o
);

	// ==========================================================
	// State record
	// ==========================================================
	typedef struct packed {
		brs_pkg::brs_state_t phase;
		logic                sw_en;
		logic                brownout_hold;
		logic                was_asleep;
		logic                wake_wait;
		logic                core_reset;
		logic                ready_flag;
		logic                level;
	} brs_seq_state_t;

	brs_seq_state_t state;
	brs_seq_state_t next_state;

	logic det_active;
	logic wait_ready;
	logic filt_done;
	logic put_done;
	logic put_run;
	logic filt_clear;

	// ==========================================================
	// Detector mode decode
	// ==========================================================
	always_comb begin
		det_active = 1'b0;
		wait_ready = 1'b0;
		unique case (brownout_mode_select_i)
			brs_pkg::MODE_ALWAYS_ON: begin
				det_active = 1'b1;
				wait_ready = 1'b1;
			end
			brs_pkg::MODE_OFF_IN_SLEEP: begin
				det_active = !sleep_i;
				wait_ready = 1'b1;
			end
			brs_pkg::MODE_SOFTWARE: begin
				// Protection only counts once ready; sleep ignored
				det_active = state.sw_en;
				wait_ready = 1'b0;
			end
			brs_pkg::MODE_ALWAYS_OFF: begin
				det_active = 1'b0;
				wait_ready = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Noise filter and power-up timer
	// ==========================================================
	// Filter restarts on any high sample, so a glitch never resets
	assign filt_clear = !(det_active && detector_ready_i && supply_low_i);

	brs_counter #(
		.WIDTH (brs_pkg::CNT_W)
	) u_filter (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  (filt_clear),
		.run_i    (1'b1),
		.limit_i  (brs_pkg::CNT_W'(FILT_CYCLES)),
		.done_o   (filt_done)
	);

	// Timer cleared during any power-on or brown-out hold
	assign put_run = (state.phase == brs_pkg::BRS_ST_TIMING);

	brs_counter #(
		.WIDTH (brs_pkg::CNT_W)
	) u_put (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  (state.phase == brs_pkg::BRS_ST_HOLD),
		.run_i    (put_run),
		.limit_i  (brs_pkg::CNT_W'(PUT_CYCLES)),
		.done_o   (put_done)
	);

	// ==========================================================
	// Sequencer
	// ==========================================================
	always_comb begin
		next_state            = state;
		next_state.level      = brownout_level_select_i;
		next_state.was_asleep = sleep_i;
		if (sw_enable_we_i) begin
			next_state.sw_en = sw_enable_wdata_i;
		end
		// Status follows the detector only while it is powered
		next_state.ready_flag = det_active && detector_ready_i;
		next_state.brownout_hold = filt_done && !filt_clear;

		// Wake from sleep waits for ready only in off-in-sleep mode
		if (state.was_asleep && !sleep_i &&
		    brownout_mode_select_i == brs_pkg::MODE_OFF_IN_SLEEP) begin
			next_state.wake_wait = 1'b1;
		end
		if (detector_ready_i ||
		    brownout_mode_select_i != brs_pkg::MODE_OFF_IN_SLEEP) begin
			next_state.wake_wait = 1'b0;
		end

		unique case (state.phase)
			brs_pkg::BRS_ST_HOLD: begin
				if (power_on_ok_i && !next_state.brownout_hold) begin
					if (power_up_timer_disable_i) begin
						next_state.phase = brs_pkg::BRS_ST_WAITRDY;
					end else begin
						next_state.phase = brs_pkg::BRS_ST_TIMING;
					end
				end
			end
			brs_pkg::BRS_ST_TIMING: begin
				if (put_done) begin
					next_state.phase = brs_pkg::BRS_ST_WAITRDY;
				end
			end
			brs_pkg::BRS_ST_WAITRDY: begin
				// In modes 11 and 10, start waits for ready and supply above threshold
				if (!wait_ready || (detector_ready_i && !supply_low_i)) begin
					next_state.phase = brs_pkg::BRS_ST_RUN;
				end
			end
			brs_pkg::BRS_ST_RUN: begin
			end
		endcase

		// Any power-on or brown-out event restarts the sequence
		if (!power_on_ok_i || next_state.brownout_hold) begin
			next_state.phase = brs_pkg::BRS_ST_HOLD;
		end

		next_state.core_reset =
			(next_state.phase != brs_pkg::BRS_ST_RUN) ||
			next_state.wake_wait;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state            <= '0;
			state.phase      <= brs_pkg::BRS_ST_HOLD;
			state.sw_en      <= brs_pkg::SW_EN_RESET;
			state.core_reset <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign detector_enable_o          = det_active;
	assign brownout_level_o           = state.level;
	assign software_brownout_enable_o = state.sw_en;
	assign brownout_ready_flag_o      = state.ready_flag;
	assign brownout_reset_o           = state.brownout_hold;
	assign power_up_timer_running_o   = put_run;
	assign core_reset_o               = state.core_reset;
	assign core_start_o               = !state.core_reset;

endmodule : brs_sequencer

/* File: tb/brs_analog_model.sv */
// Model of the analog power-on and brown-out detectors
`timescale 1ns/10ps
module brs_analog_model #(
	parameter int unsigned READY_DELAY = 40
) (
	input  wire logic clk_i,
	input  wire logic supply_up_i,
	input  wire logic supply_dip_i,
	input  wire logic detector_enable_i,
	output logic      power_on_ok_o,
	output logic      supply_low_o,
	output logic      detector_ready_o
);
	int unsigned warm = 0;
	assign power_on_ok_o = supply_up_i;
	// Unpowered comparator reads 0, never a stale low-supply value
	assign supply_low_o = supply_dip_i & detector_enable_i;
	// Ready only after a warm-up; drops at once when power is removed
	assign detector_ready_o = detector_enable_i && warm >= READY_DELAY;
	// Counted on the edge, so no race with the bench's stimulus step
	always @(posedge clk_i) begin
		warm <= detector_enable_i ? warm + 1 : 0;
	end
endmodule : brs_analog_model

/* File: tb/brs_sequencer_checker.sv */
// Checker of the brown-out reset sequencer ports
`timescale 1ns/10ps
module brs_sequencer_checker #(
	parameter int unsigned PUT_CYCLES  = 20,
	parameter int unsigned FILT_CYCLES = 3
) (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       power_on_ok_i,
	input wire logic       sleep_i,
	input wire logic       supply_low_i,
	input wire logic [1:0] brownout_mode_select_i,
	input wire logic       power_up_timer_disable_i,
	input wire logic       detector_enable_o,
	input wire logic       software_brownout_enable_o,
	input wire logic       brownout_reset_o,
	input wire logic       power_up_timer_running_o,
	input wire logic       core_reset_o
);
	logic [31:0] run_cnt;
	// Cycles spent counting, so the power-up timer length can be bounded
	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i)
			run_cnt <= '0;
		else
			run_cnt <= power_up_timer_running_o ? run_cnt + 1 : '0;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// ==========
	// Assertions
	por_hold_a: assert property (!power_on_ok_i |=> core_reset_o)
		else $error("core released with supply low");
	timer_len_a: assert property ($fell(power_up_timer_running_o) &&
		power_on_ok_i && !brownout_reset_o |-> run_cnt >= PUT_CYCLES &&
		run_cnt <= PUT_CYCLES + 1) else $error("timer length wrong");
	timer_hold_a: assert property (power_up_timer_running_o |->
		core_reset_o) else $error("core released while timing");
	timer_skip_a: assert property (power_up_timer_disable_i &&
		$past(power_up_timer_disable_i) |-> !power_up_timer_running_o)
		else $error("bypassed timer ran");
	timer_start_a: assert property ($rose(power_up_timer_running_o) |->
		$past(power_on_ok_i) && !brownout_reset_o) else $error("early timer");
	brownout_hold_a: assert property (brownout_reset_o |-> core_reset_o)
		else $error("core released in brown-out");
	supply_filter_a: assert property ($rose(brownout_reset_o) |->
		$past(supply_low_i) && $past(supply_low_i, FILT_CYCLES - 1))
		else $error("brown-out not filtered");
	mode_on_a: assert property (brownout_mode_select_i == 2'h3 |->
		detector_enable_o) else $error("detector off in mode 11");
	mode_sleep_a: assert property (brownout_mode_select_i == 2'h2 |->
		detector_enable_o == !sleep_i) else $error("mode 10 power wrong");
	mode_sw_a: assert property (brownout_mode_select_i == 2'h1 |->
		detector_enable_o == software_brownout_enable_o)
		else $error("mode 01 power wrong");
	mode_off_a: assert property (brownout_mode_select_i == 2'h0 |->
		!detector_enable_o) else $error("detector on in mode 00");
	start_c: cover property ($fell(core_reset_o));
	brownout_c: cover property ($rose(brownout_reset_o));
	timer_c: cover property ($fell(power_up_timer_running_o));
endmodule : brs_sequencer_checker
bind brs_sequencer brs_sequencer_checker #(.PUT_CYCLES(PUT_CYCLES),
	.FILT_CYCLES(FILT_CYCLES)) u_brs_sequencer_checker (.*);

/* File: tb/brownout_reset_sequencer_test.sv */
// Self-checking bench of the brown-out reset sequencer
`timescale 1ns/10ps
module brownout_reset_sequencer_test;
	localparam int unsigned PUT = 20;
	localparam int unsigned FIL = 3;
	logic       clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic       sup_up = 1'b0;
	logic       dip = 1'b0;
	logic       sleep_i = 1'b0;
	logic       brownout_level_select_i = 1'b0;
	logic       power_up_timer_disable_i = 1'b0;
	logic       sw_enable_we_i = 1'b0;
	logic       sw_enable_wdata_i = 1'b0;
	logic [1:0] brownout_mode_select_i = 2'h0;
	logic       power_on_ok_i, supply_low_i, detector_ready_i;
	logic       detector_enable_o, brownout_level_o, core_start_o;
	logic       software_brownout_enable_o, brownout_ready_flag_o;
	logic       brownout_reset_o, power_up_timer_running_o, core_reset_o;
	int         err_total = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	int         n;
	always #12.5 clk_i = ~clk_i;
	brs_sequencer #(.PUT_CYCLES(PUT), .FILT_CYCLES(FIL)) u_brs_sequencer (.*);
	brs_analog_model u_brs_analog_model (.clk_i(clk_i), .supply_up_i(sup_up),
		.supply_dip_i(dip), .detector_enable_i(detector_enable_o),
		.power_on_ok_o(power_on_ok_i), .supply_low_o(supply_low_i),
		.detector_ready_o(detector_ready_i));
	// ==========
	// Tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic wait_start(input int lim);
		n = 0;
		while (core_start_o !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask : wait_start
	task automatic boot(input logic [1:0] m, input logic d);
		resetn_i = 1'b0;
		sup_up = 1'b0;
		sleep_i = 1'b0;
		brownout_mode_select_i = m;
		power_up_timer_disable_i = d;
		tick(6);
		resetn_i = 1'b1;
		tick(2);
		sup_up = 1'b1;
	endtask : boot
	task automatic sw_write(input logic v);
		sw_enable_wdata_i = v;
		sw_enable_we_i = 1'b1;
		tick(1);
		sw_enable_we_i = 1'b0;
		tick(1);
	endtask : sw_write
	// Hang guard, well above the longest expected run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			$display("unexpected at %0t: run hung", $time);
			stop_test();
		end
	end
	// ==========
	// Tests
	initial begin
		boot(2'h0, 1'b0);
		wait_start(PUT + 10);
		chk(n >= PUT + 2 && n <= PUT + 4, "timer length");
		chk(detector_enable_o === 1'b0, "mode 00 power");
		brownout_level_select_i = 1'b1;
		tick(2);
		chk(brownout_level_o === 1'b1, "level copy");
		sup_up = 1'b0;
		tick(1);
		chk(core_reset_o === 1'b1, "power-on hold");
		$display("test power-up done");
		boot(2'h0, 1'b1);
		wait_start(10);
		chk(n <= 4, "bypass length");
		$display("test bypass done");
		boot(2'h3, 1'b0);
		wait_start(80);
		chk(n > PUT + 4 && core_start_o === 1'b1, "ready wait");
		chk(brownout_ready_flag_o === 1'b1, "ready flag");
		sleep_i = 1'b1;
		tick(3);
		sleep_i = 1'b0;
		tick(1);
		chk(core_start_o === 1'b1, "wake delayed");
		dip = 1'b1;
		tick(FIL - 1);
		dip = 1'b0;
		tick(2);
		chk(core_reset_o === 1'b0, "glitch reset");
		dip = 1'b1;
		tick(FIL + 1);
		chk(brownout_reset_o === 1'b1 && core_reset_o === 1'b1,
			"brownout hold");
		dip = 1'b0;
		wait_start(PUT + 10);
		chk(n >= PUT && core_start_o === 1'b1, "timer restart");
		$display("test always-on done");
		boot(2'h2, 1'b1);
		wait_start(80);
		chk(core_start_o === 1'b1, "sleep-off start");
		sleep_i = 1'b1;
		tick(1);
		chk(detector_enable_o === 1'b0, "sleep power");
		sleep_i = 1'b0;
		tick(1);
		chk(core_reset_o === 1'b1, "wake hold");
		wait_start(80);
		chk(n > 30 && core_start_o === 1'b1, "wake wait");
		$display("test sleep-off done");
		boot(2'h1, 1'b1);
		wait_start(10);
		chk(n <= 4, "software start");
		sw_write(1'b0);
		chk(detector_enable_o === 1'b0 &&
			software_brownout_enable_o === 1'b0, "software off");
		sw_write(1'b1);
		sleep_i = 1'b1;
		tick(45);
		chk(detector_enable_o === 1'b1, "sleep kept power");
		chk(brownout_ready_flag_o === 1'b1, "software ready");
		$display("test software done");
		stop_test();
	end
endmodule : brownout_reset_sequencer_test
